//--- rtl/vrc_cmd_handler.sv
// recording command handler: link decode, slots, table-write budgets, bus
//
// Contract
// RQ1: function code 0 starts recording and triggers internal preparation.
// RQ2: host sets video flag and leaves slot and address fields reserved.
// RQ3: start-recording busy ends within one second, never reports an error.
// RQ4: start picks single-slot mode unless any slot two to eight is assigned.
// RQ5: eight-update sliding average of table writes within 100ms or 150ms.
// RQ6: no table write over 750ms, only one such long write per eight.
// RQ7: code 1 binds the next single-block write address to the named slot.
// RQ8: eight slots active together, slot field zero selects the first.
// RQ9: repeated writes to a registered area are table writes under budget.
// RQ10: slot assignments vanish at power cycle and after each suspend.
// RQ11: slot updates accepted before start and while recording.
// RQ12: slot update busy 10ms, its write 250ms or 500ms by capacity.
// RQ13: update naming an already assigned slot sets the error flag.
// RQ14: host releases a slot before re-pointing it to another address.
// RQ15: card may refuse recording silently when slot updates are missing.
// RQ16: code 4 marks next single-block write as cluster update, 10/250ms.
// RQ17: code 5 suspends, storing next recording unit address for status.
// RQ18: host must resume to restart; no performance promised meanwhile.
// RQ19: any write in the allocation unit of the suspension address clears it; the code clears it only on a single-block write while not recording.
// RQ20: suspend with a stored suspension address leaves it unchanged.
// RQ21: suspend mid recording unit releases slots, units, zeroes address.
// RQ22: host buffers stream data across eight table update cycles.
// RQ23: a zero suspension address is the sole sign of no suspend.
// RQ24: busy holds the data line low until done, within the maximum time.
`timescale 1ns/1ps
module vrc_cmd_handler
#(
  parameter int unsigned CYC_PER_MS = vrc_pkg::CLK_HZ / 1000,
  parameter int unsigned NSLOT      = vrc_pkg::NUM_SLOTS
)
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire vrc_pkg::vrc_link_t lnk_in,
  output logic                   rsp_valid,
  output logic                   error_flag_bit,
  output logic                   dat0_o,
  output logic                   dat0_oe
);

  // busy limits in cycles
  localparam logic [31:0] CYC_START = 32'(vrc_pkg::T_START_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_UPD   = 32'(vrc_pkg::T_UPD_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_WR_HC = 32'(vrc_pkg::T_WR_HC_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_WR_XC = 32'(vrc_pkg::T_WR_XC_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_SUSP  = 32'(vrc_pkg::T_SUSP_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_AVG1  = 32'(vrc_pkg::T_AVG1_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_AVGM  = 32'(vrc_pkg::T_AVGM_MS * CYC_PER_MS);
  localparam logic [31:0] CYC_MAXTW = 32'(vrc_pkg::T_MAXTW_MS * CYC_PER_MS);

  ////////////////////////////////////////////////////////////////////////////
  // link pins: two-stage synchroniser, edge found on the second stage

  vrc_pkg::vrc_link_t lnk_s1;
  vrc_pkg::vrc_link_t lnk_s2;
  logic               lnk_clk_d;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lnk_s1    <= '0;
      lnk_s2    <= '0;
      lnk_clk_d <= 1'b0;
    end
    else
    begin
      lnk_s1    <= lnk_in;
      lnk_s2    <= lnk_s1;
      lnk_clk_d <= lnk_s2.clk;
    end
  end

  logic lnk_rise;
  logic cmd_evt;
  logic wr_evt;
  vrc_pkg::vrc_state_t state;

  assign lnk_rise = lnk_s2.clk && !lnk_clk_d;
  // while busy the host must wait, so new frames are ignored
  assign cmd_evt = lnk_rise && lnk_s2.cmd_valid && (state == vrc_pkg::ST_IDLE);
  assign wr_evt  = lnk_rise && lnk_s2.wr_valid && lnk_s2.wr_single
                   && (state == vrc_pkg::ST_IDLE);

  logic [3:0] fc;
  logic [2:0] slot_id;
  assign fc      = lnk_s2.arg.function_code_field;
  assign slot_id = lnk_s2.arg.count_or_slot_field;

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  logic        ext_cap;
  logic        partial_ru;
  logic        req_dir;
  logic        sw_done;
  logic [23:0] next_ru;
  logic [4:0]  au_shift;
  logic [23:0] suspension_address;
  logic [31:0] last_tw;

  logic        bus_wr_q;
  logic [7:0]  bus_addr_q;
  logic        bus_take;

  assign bus_take = hsel && hready && htrans[1];
  assign sw_done  = bus_wr_q && (bus_addr_q == vrc_pkg::OFS_CTRL)
                    && hwdata[vrc_pkg::CTRL_DONE];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_wr_q   <= 1'b0;
      bus_addr_q <= 8'h00;
    end
    else
    begin
      bus_wr_q   <= bus_take && hwrite && (hsize == 3'h2);
      bus_addr_q <= haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_cap    <= 1'b0;
      partial_ru <= 1'b0;
      req_dir    <= 1'b0;
      next_ru    <= vrc_pkg::NEXT_RU_RST;
      au_shift   <= vrc_pkg::AU_SHIFT_RST;
    end
    else if (bus_wr_q)
    begin
      unique case (bus_addr_q)
        vrc_pkg::OFS_CTRL:
        begin
          ext_cap    <= hwdata[vrc_pkg::CTRL_EXTCAP];
          partial_ru <= hwdata[vrc_pkg::CTRL_PARTIAL];
          req_dir    <= hwdata[vrc_pkg::CTRL_REQDIR];
        end
        vrc_pkg::OFS_NEXT_RU: next_ru  <= hwdata[23:0];
        vrc_pkg::OFS_AUSHIFT: au_shift <= hwdata[4:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // directory slots

  logic [NSLOT-1:0] slot_valid;
  logic [NSLOT-1:0] slot_match;
  logic [NSLOT-1:0] slot_assign;
  logic             slot_release;
  logic             pend_dir;
  logic [2:0]       pend_slot;
  logic             pend_ci;

  for (genvar g = 0; g < NSLOT; g++)
  begin : g_slot
    // the pending slot takes the address of the next single-block write
    assign slot_assign[g] = wr_evt && pend_dir && (pend_slot == 3'(g)); // RQ7
    vrc_dir_slot u_slot
    (
      .clk        (hclk),
      .rst_n      (hresetn),
      .assign_en  (slot_assign[g]),
      .release_en (slot_release),
      .addr_in    (lnk_s2.wr_addr),
      .probe_addr (lnk_s2.wr_addr),
      .valid      (slot_valid[g]),
      .match      (slot_match[g])
    );
  end

  // slot field zero is the first of eight concurrent slots
  logic slot_busy_err;
  assign slot_busy_err = slot_valid[slot_id]; // RQ8 RQ13

  logic is_start;
  logic is_dir;
  logic is_ci;
  logic is_susp;
  assign is_start = cmd_evt && (fc == vrc_pkg::FC_START);
  assign is_dir   = cmd_evt && (fc == vrc_pkg::FC_UPD_DIR);
  assign is_ci    = cmd_evt && (fc == vrc_pkg::FC_UPD_CI);
  assign is_susp  = cmd_evt && (fc == vrc_pkg::FC_SUSPEND);

  // every suspend drops all slot assignments; reset covers power cycle
  assign slot_release = is_susp; // RQ10

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pend_dir  <= 1'b0;
      pend_slot <= 3'h0;
      pend_ci   <= 1'b0;
    end
    else if (is_dir && !slot_busy_err)
    begin
      // accepted whether or not recording is running
      pend_dir  <= 1'b1; // RQ11
      pend_slot <= slot_id;
    end
    else if (is_ci)
    begin
      pend_ci <= 1'b1; // RQ16
    end
    else if (is_susp)
    begin
      pend_dir <= 1'b0;
      pend_ci  <= 1'b0;
    end
    else if (wr_evt)
    begin
      if (pend_dir)
        pend_dir <= 1'b0;
      else
        pend_ci <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // recording, mode, allocation unit and suspension address

  logic recording;
  logic multi_slot;
  logic au_active;
  logic au_hit;

  assign au_hit = (suspension_address != 24'h00_0000)
                  && ((lnk_s2.wr_addr >> au_shift)
                      == ({8'h00, suspension_address} >> au_shift));

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      recording  <= 1'b0;
      multi_slot <= 1'b0;
      au_active  <= 1'b0;
    end
    else if (is_start)
    begin
      // slot one alone keeps the default single-slot mode
      multi_slot <= |slot_valid[NSLOT-1:1]; // RQ4
      // with req_dir set, recording is silently refused if no slot exists
      recording  <= !(req_dir && !(|slot_valid)); // RQ1 RQ15
      au_active  <= !(req_dir && !(|slot_valid));
    end
    else if (is_susp)
    begin
      recording <= 1'b0; // RQ17
      if (partial_ru && suspension_address == 24'h00_0000)
        au_active <= 1'b0; // RQ21
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      suspension_address <= 24'h00_0000;
    end
    else if (is_susp)
    begin
      // a stored address survives a second suspend; zero means no suspend
      if (suspension_address != 24'h00_0000)
        suspension_address <= suspension_address; // RQ20
      else if (partial_ru)
        suspension_address <= 24'h00_0000; // RQ21 RQ23
      else
        suspension_address <= next_ru; // RQ17
    end
    else if (wr_evt && !recording && au_hit)
    begin
      suspension_address <= 24'h00_0000; // RQ19
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table-write history and budget

  logic [31:0] hist [vrc_pkg::HIST_LEN];
  logic [31:0] sum7;
  logic [31:0] sum8;
  logic        long_in7;
  logic [31:0] avg_cyc;
  logic [31:0] total_cyc;
  logic [31:0] remain_cyc;
  logic [31:0] cap_cyc;
  logic [31:0] tw_limit;

  always_comb
  begin
    sum7     = 32'h0000_0000;
    long_in7 = 1'b0;
    for (int i = 0; i < vrc_pkg::HIST_LEN - 1; i++)
    begin
      sum7     = sum7 + hist[i];
      long_in7 = long_in7 || (hist[i] > avg_cyc);
    end
    sum8 = sum7 + hist[vrc_pkg::HIST_LEN-1];
  end

  // budget keeps the eight-write sum under eight times the mode average
  assign avg_cyc    = multi_slot ? CYC_AVGM : CYC_AVG1; // RQ5
  assign total_cyc  = avg_cyc << 3;
  assign remain_cyc = (total_cyc > sum7 + 32'h0000_0001)
                      ? total_cyc - sum7 : 32'h0000_0002; // RQ5
  // only one over-average write may fall into any eight
  assign cap_cyc    = long_in7 ? avg_cyc : CYC_MAXTW; // RQ6
  assign tw_limit   = (remain_cyc < cap_cyc) ? remain_cyc : cap_cyc; // RQ6

  ////////////////////////////////////////////////////////////////////////////
  // busy sequencer: data line held low until done or limit

  vrc_pkg::vrc_wkind_t wkind;
  logic [31:0]         busy_cnt;
  logic [31:0]         busy_lim;
  logic                busy_end;
  logic [31:0]         cmd_lim;
  logic [31:0]         wr_lim;
  vrc_pkg::vrc_wkind_t next_wkind;

  always_comb
  begin
    unique case (fc)
      vrc_pkg::FC_START:   cmd_lim = CYC_START; // RQ3
      vrc_pkg::FC_SUSPEND: cmd_lim = CYC_SUSP;
      default:             cmd_lim = CYC_UPD; // RQ12 RQ16
    endcase
  end

  always_comb
  begin
    if (pend_dir)
    begin
      next_wkind = vrc_pkg::WK_DIR;
      wr_lim     = ext_cap ? CYC_WR_XC : CYC_WR_HC; // RQ12
    end
    else if (pend_ci)
    begin
      next_wkind = vrc_pkg::WK_CI;
      wr_lim     = CYC_WR_HC; // RQ16
    end
    else if (|slot_match)
    begin
      // registered area rewritten without a fresh update
      next_wkind = vrc_pkg::WK_TABLE; // RQ9
      wr_lim     = tw_limit;
    end
    else
    begin
      next_wkind = vrc_pkg::WK_NONE;
      wr_lim     = 32'h0000_0000;
    end
  end

  assign busy_end = sw_done || (busy_cnt + 32'h0000_0001 >= busy_lim); // RQ24

  logic cmd_busy;
  assign cmd_busy = is_start || is_ci || is_susp
                    || (is_dir && !slot_busy_err);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state    <= vrc_pkg::ST_IDLE;
      wkind    <= vrc_pkg::WK_NONE;
      busy_cnt <= 32'h0000_0000;
      busy_lim <= 32'h0000_0001;
    end
    else
    begin
      unique case (state)
        vrc_pkg::ST_IDLE:
        begin
          busy_cnt <= 32'h0000_0000;
          if (cmd_busy)
          begin
            state    <= vrc_pkg::ST_CMD_BUSY;
            busy_lim <= cmd_lim;
          end
          else if (wr_evt && next_wkind != vrc_pkg::WK_NONE)
          begin
            state    <= vrc_pkg::ST_WR_BUSY;
            wkind    <= next_wkind;
            busy_lim <= wr_lim;
          end
        end
        vrc_pkg::ST_CMD_BUSY,
        vrc_pkg::ST_WR_BUSY:
        begin
          busy_cnt <= busy_cnt + 32'h0000_0001;
          if (busy_end)
            state <= vrc_pkg::ST_IDLE;
        end
        default: state <= vrc_pkg::ST_IDLE;
      endcase
    end
  end

  // a finished table write enters the sliding window
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < vrc_pkg::HIST_LEN; i++)
        hist[i] <= 32'h0000_0000;
      last_tw <= 32'h0000_0000;
    end
    else if (state == vrc_pkg::ST_WR_BUSY && busy_end
             && wkind == vrc_pkg::WK_TABLE)
    begin
      hist[0] <= busy_cnt + 32'h0000_0001; // RQ5 RQ6
      for (int i = 1; i < vrc_pkg::HIST_LEN; i++)
        hist[i] <= hist[i-1];
      last_tw <= busy_cnt + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response and data line

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rsp_valid      <= 1'b0;
      error_flag_bit <= 1'b0;
      dat0_o         <= 1'b0;
      dat0_oe        <= 1'b0;
    end
    else
    begin
      rsp_valid      <= cmd_evt;
      // only an update naming an assigned slot reports an error
      error_flag_bit <= is_dir && slot_busy_err; // RQ13 RQ3
      dat0_o         <= 1'b0;
      dat0_oe        <= (state != vrc_pkg::ST_IDLE) && !busy_end; // RQ24
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus read path: zero wait states, always OKAY

  logic [31:0] rd_val;

  always_comb
  begin
    unique case (haddr[7:0])
      vrc_pkg::OFS_CTRL:
        rd_val = {28'h000_0000, req_dir, partial_ru, ext_cap, 1'b0};
      vrc_pkg::OFS_STATUS:
        rd_val = {8'h00, 8'(slot_valid), 4'h0, fc, 2'b00, au_active,
                  pend_ci, pend_dir, dat0_oe, multi_slot, recording};
      vrc_pkg::OFS_NEXT_RU: rd_val = {8'h00, next_ru};
      vrc_pkg::OFS_SUSADDR: rd_val = {8'h00, suspension_address};
      vrc_pkg::OFS_AUSHIFT: rd_val = {27'h000_0000, au_shift};
      vrc_pkg::OFS_LAST_TW: rd_val = last_tw;
      vrc_pkg::OFS_TW_SUM:  rd_val = sum8;
      default:              rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hrdata    <= (bus_take && !hwrite) ? rd_val : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule

//--- rtl/vrc_pkg.sv
// package: constants, field layouts and types of the recording handler
package vrc_pkg;

  localparam int unsigned CLK_HZ    = 32'h0262_5A00; // 40 MHz
  localparam int unsigned NUM_SLOTS = 32'h0000_0008;
  localparam int unsigned HIST_LEN  = 32'h0000_0008;

  // times in milliseconds
  localparam int unsigned T_START_MS  = 32'h0000_03E8; // 1000
  localparam int unsigned T_UPD_MS    = 32'h0000_000A; // 10
  localparam int unsigned T_WR_HC_MS  = 32'h0000_00FA; // 250
  localparam int unsigned T_WR_XC_MS  = 32'h0000_01F4; // 500
  localparam int unsigned T_SUSP_MS   = 32'h0000_00FA; // 250
  localparam int unsigned T_AVG1_MS   = 32'h0000_0064; // 100
  localparam int unsigned T_AVGM_MS   = 32'h0000_0096; // 150
  localparam int unsigned T_MAXTW_MS  = 32'h0000_02EE; // 750

  // function codes
  localparam logic [3:0] FC_START   = 4'h0;
  localparam logic [3:0] FC_UPD_DIR = 4'h1;
  localparam logic [3:0] FC_UPD_CI  = 4'h4;
  localparam logic [3:0] FC_SUSPEND = 4'h5;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_NEXT_RU = 8'h08;
  localparam logic [7:0] OFS_SUSADDR = 8'h0C;
  localparam logic [7:0] OFS_AUSHIFT = 8'h10;
  localparam logic [7:0] OFS_LAST_TW = 8'h14;
  localparam logic [7:0] OFS_TW_SUM  = 8'h18;

  // ctrl bit positions
  localparam int unsigned CTRL_DONE    = 0;
  localparam int unsigned CTRL_EXTCAP  = 1;
  localparam int unsigned CTRL_PARTIAL = 2;
  localparam int unsigned CTRL_REQDIR  = 3;

  localparam logic [4:0]  AU_SHIFT_RST = 5'h0D;
  localparam logic [23:0] NEXT_RU_RST  = 24'h00_0400;

  typedef struct packed {
    logic [3:0]  function_code_field;
    logic        video_flag;
    logic [2:0]  count_or_slot_field;
    logic [23:0] address;
  } vrc_arg_t;

  // link pins as seen by the card
  typedef struct packed {
    logic        clk;
    logic        cmd_valid;
    vrc_arg_t    arg;
    logic        wr_valid;
    logic [31:0] wr_addr;
    logic        wr_single;
  } vrc_link_t;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD_BUSY, ST_WR_BUSY} vrc_state_t;
  typedef enum logic [1:0] {WK_NONE, WK_DIR, WK_CI, WK_TABLE} vrc_wkind_t;

endpackage

//--- rtl/vrc_dir_slot.sv
// one directory slot: holds an assigned 512-byte area address
`timescale 1ns/1ps
module vrc_dir_slot
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        assign_en,
  input  wire logic        release_en,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] probe_addr,
  output logic             valid,
  output logic             match
);

  logic [31:0] addr;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      valid <= 1'b0;
      addr  <= 32'h0000_0000;
    end
    else if (release_en)
    begin
      valid <= 1'b0;
    end
    else if (assign_en)
    begin
      valid <= 1'b1;
      addr  <= addr_in;
    end
  end

  assign match = valid && (addr == probe_addr);

endmodule

//--- verification/vrc_cmd_handler_chk.sv
// port checker for the recording command handler
`timescale 1ns/1ps
module vrc_chk
#(
  parameter int unsigned CYC_PER_MS = 4
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rsp_valid,
  input wire logic        error_flag_bit,
  input wire logic        dat0_o,
  input wire logic        dat0_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  int unsigned bcnt;

  // the one-second start is the longest busy of all functions
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bcnt <= 0;
    else
      bcnt <= dat0_oe ? bcnt + 1 : 0;
  end

  //////////////////////////////////////////////////////////////////////////
  a_busy_low: assert property (dat0_oe |-> !dat0_o)
    else $error("busy shown without data line low");
  a_busy_bound: assert property (bcnt <= 1000 * CYC_PER_MS + 1)
    else $error("busy longer than the longest limit");
  a_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("response pulse longer than one cycle");
  a_err_in_rsp: assert property (error_flag_bit |-> rsp_valid)
    else $error("error flag outside a response");
  a_err_no_busy: assert property (rsp_valid && error_flag_bit
    |-> !dat0_oe ##1 !dat0_oe)
    else $error("refused slot update went busy");
  a_quiet_busy: assert property (dat0_oe && $past(dat0_oe) |-> !rsp_valid)
    else $error("response during busy");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or failed");
  a_read_idle: assert property (!$past(hsel && htrans[1] && !hwrite && hready)
    |-> hrdata == 32'h0000_0000)
    else $error("read data outside a data phase");

  c_err: cover property (rsp_valid && error_flag_bit);
  c_busy_end: cover property ($fell(dat0_oe));
  c_long: cover property (bcnt == 250 * CYC_PER_MS);
endmodule

//--- verification/vrc_host_model.sv
// host controller model: sends link frames for commands and writes
`timescale 1ns/1ps
module vrc_host_model
(
  output vrc_pkg::vrc_link_t lnk
);
  initial lnk = '0;

  function automatic logic [31:0] arg(input logic [3:0] fc,
                                      input logic [2:0] sl);
    return {fc, 1'b1, sl, 24'h00_0000};
  endfunction

  // link clock stands still outside frames; 200 ns period inside
  task automatic frame(input logic c, input logic [31:0] v);
    #3;
    lnk.cmd_valid = c;
    lnk.wr_valid = !c;
    lnk.wr_single = !c;
    if (c)
      lnk.arg = v;
    else
      lnk.wr_addr = v;
    #100 lnk.clk = 1'b1;
    #100 lnk.clk = 1'b0;
    lnk.cmd_valid = 1'b0;
    lnk.wr_valid = 1'b0;
    lnk.arg = ~lnk.arg;
    lnk.wr_addr = ~lnk.wr_addr;
  endtask
endmodule

//--- verification/test_video_record_cmd_handler.sv
// self-checking bench for the recording command handler
`timescale 1ns/1ps
module test_video_record_cmd_handler;
  localparam int CPM = 4;
  logic               hclk = 1'b0;
  logic               hresetn = 1'b0;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0000_0000;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0000_0000;
  wire  [31:0]        hrdata;
  wire                hreadyout;
  wire                rsp_valid;
  wire                error_flag_bit;
  wire                dat0_oe;
  vrc_pkg::vrc_link_t lnk;
  int                 n_mismatch = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  int                 bc;
  int                 n;
  int                 tw[$];
  logic [31:0]        q;
  logic [31:0]        a;
  logic               r;
  logic               e;
  logic               b;

  vrc_cmd_handler #(.CYC_PER_MS(CPM)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(), .lnk_in(lnk), .rsp_valid(rsp_valid),
    .error_flag_bit(error_flag_bit), .dat0_o(), .dat0_oe(dat0_oe));
  vrc_host_model host_u (.lnk(lnk));

  always #12.5 hclk = ~hclk;

  //////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (n_mismatch == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc > 40000)
    begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] x);
    total_checks++;
    if (v !== x)
    begin
      n_mismatch++;
      $display("wrong value %s exp %h seen %h", s, x, v);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h00_0000, ad};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic rd(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0000_0000);
  endtask

  // one frame, watching response and busy
  task automatic link(input logic c, input logic [31:0] v);
    {r, e, b, bc} = '0;
    fork
      host_u.frame(c, v);
      repeat (12)
      begin
        @(negedge hclk);
        if (rsp_valid === 1'b1)
          {r, e} = {1'b1, error_flag_bit};
        b |= dat0_oe === 1'b1;
        bc += dat0_oe === 1'b1;
      end
    join
  endtask

  // dn: busy cycle of the done write, 0 runs to the limit
  task automatic hold(input int lim, input int dn, output int m);
    m = bc;
    while (dat0_oe === 1'b1 && m < lim + 9)
    begin
      if (m == dn)
        bus(1'b1, vrc_pkg::OFS_CTRL, 32'h0000_0001);
      @(negedge hclk);
      m += dat0_oe === 1'b1;
    end
    chk("busy_len", m <= lim + 1, 1'b1);
  endtask

  // window of the last eight table writes
  task automatic tab(input int avg, input int k);
    int m;
    int s;
    int lg;
    repeat (k)
    begin
      link(1'b0, 32'h0000_2000);
      chk("tw_busy", b, 1'b1);
      hold(750 * CPM, $urandom % 2 ? 5 + $urandom % (avg * CPM) : 0, m);
      tw.push_back(m);
      if (tw.size() > 8)
        void'(tw.pop_front());
      s = 0;
      lg = 0;
      foreach (tw[i])
      begin
        s += tw[i];
        lg += tw[i] > avg * CPM + 4;
      end
      chk("tw_sum", s <= 8 * (avg * CPM + 1), 1'b1);
      chk("tw_long", lg <= 1, 1'b1);
    end
  endtask

  task automatic cmd(input logic [3:0] fc, input logic [2:0] sl);
    link(1'b1, host_u.arg(fc, sl));
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'h0000_9554));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd(vrc_pkg::OFS_NEXT_RU);
    chk("next_ru", q, 32'h0000_0400);
    rd(vrc_pkg::OFS_AUSHIFT);
    chk("au_shift", q, 32'h0000_000D);
    bus(1'b1, vrc_pkg::OFS_SUSADDR, 32'hFFFF_FFFF);
    rd(vrc_pkg::OFS_SUSADDR);
    chk("sus_rst", q, 32'h0000_0000);
    rd(8'h40);
    chk("unmapped", q, 32'h0000_0000);
    cmd(vrc_pkg::FC_UPD_DIR, 3'h0);
    chk("upd_rsp", {r, e, b}, 3'b101);
    hold(10 * CPM, 0, n);
    link(1'b0, 32'h0000_2000);
    chk("dir_wr", b, 1'b1);
    hold(250 * CPM, 0, n);
    rd(vrc_pkg::OFS_STATUS);
    chk("slot0", q[23:16], 8'h01);
    cmd(vrc_pkg::FC_UPD_DIR, 3'h0);
    chk("dup_rsp", {r, e, b}, 3'b110);
    cmd(vrc_pkg::FC_START, 3'h0);
    chk("start_rsp", {r, e, b}, 3'b101);
    hold(1000 * CPM, 40, n);
    rd(vrc_pkg::OFS_STATUS);
    chk("single", q[1:0], 2'b01);
    tab(100, 10);
    cmd(vrc_pkg::FC_UPD_DIR, 3'h7);
    chk("upd7_rsp", {r, e, b}, 3'b101);
    hold(10 * CPM, 0, n);
    bus(1'b1, vrc_pkg::OFS_CTRL, 32'h0000_0002);
    link(1'b0, 32'h0000_4000);
    hold(500 * CPM, 0, n);
    chk("ext_len", n > 250 * CPM, 1'b1);
    cmd(vrc_pkg::FC_START, 3'h0);
    hold(1000 * CPM, 20, n);
    rd(vrc_pkg::OFS_STATUS);
    chk("multi", q[1:0], 2'b11);
    tab(150, 6);
    cmd(vrc_pkg::FC_UPD_CI, 3'h0);
    chk("ci_rsp", {r, e, b}, 3'b101);
    hold(10 * CPM, 0, n);
    link(1'b0, 32'h0000_8000);
    chk("ci_wr", b, 1'b1);
    hold(250 * CPM, 0, n);
    cmd(4'h3, 3'h0);
    chk("unknown", {r, e, b}, 3'b100);
    a = $urandom & 32'h00FF_FFF0 | 32'h0000_0010;
    bus(1'b1, vrc_pkg::OFS_NEXT_RU, a);
    cmd(vrc_pkg::FC_SUSPEND, 3'h0);
    hold(250 * CPM, 0, n);
    rd(vrc_pkg::OFS_SUSADDR);
    chk("suspension_address", q, a);
    rd(vrc_pkg::OFS_STATUS);
    chk("released", {q[23:16], q[0]}, 9'h000);
    bus(1'b1, vrc_pkg::OFS_NEXT_RU, a ^ 32'h0080_0000);
    cmd(vrc_pkg::FC_SUSPEND, 3'h0);
    hold(250 * CPM, 0, n);
    rd(vrc_pkg::OFS_SUSADDR);
    chk("sus_keep", q, a);
    link(1'b0, a | 32'h0000_0001);
    rd(vrc_pkg::OFS_SUSADDR);
    chk("sus_clr", q, 32'h0000_0000);
    cmd(vrc_pkg::FC_START, 3'h0);
    hold(1000 * CPM, 20, n);
    bus(1'b1, vrc_pkg::OFS_CTRL, 32'h0000_0004);
    cmd(vrc_pkg::FC_SUSPEND, 3'h0);
    hold(250 * CPM, 0, n);
    rd(vrc_pkg::OFS_SUSADDR);
    chk("partial", q, 32'h0000_0000);
    rd(vrc_pkg::OFS_STATUS);
    chk("au_free", q[5], 1'b0);
    cmd(vrc_pkg::FC_UPD_DIR, 3'h2);
    hold(10 * CPM, 0, n);
    link(1'b0, 32'h0000_6000);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b1, vrc_pkg::OFS_CTRL, 32'h0000_0008);
    cmd(vrc_pkg::FC_START, 3'h0);
    rd(vrc_pkg::OFS_STATUS);
    chk("power", q[23:16], 8'h00);
    chk("refused", q[0], 1'b0);
    finish_test();
  end
endmodule

bind vrc_cmd_handler vrc_chk #(.CYC_PER_MS(CYC_PER_MS)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .rsp_valid(rsp_valid),
  .error_flag_bit(error_flag_bit), .dat0_o(dat0_o), .dat0_oe(dat0_oe));
